// ### design/cbc_pkg.sv
// Package for the bridge configuration register group.
// Assumes byte addressed configuration space, dword aligned accesses.
package cbc_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_MAKER = 8'h40;
	localparam logic [7:0] OFS_PRODUCT = 8'h42;
	localparam logic [7:0] OFS_LEGACY = 8'h44;
	localparam logic [7:0] OFS_SYS = 8'h80;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] MAKER_RST = 16'h0000;
	localparam logic [15:0] PRODUCT_RST = 16'h0000;
	localparam logic [31:0] LEGACY_RST = 32'h0000_0001;
	localparam logic [31:0] SYS_RST = 32'h0800_9060;

	// ----------------------------------------
	// System setup field positions
	// ----------------------------------------
	localparam int SYS_SHIFT_LO = 30;
	localparam int SYS_TIE_AB = 29;
	localparam int SYS_TIE_ALL = 28;
	localparam int SYS_OSC_RSVD = 27;
	localparam int SYS_ROUTE = 26;
	localparam int SYS_FLAG = 25;
	localparam int SYS_ENABLE = 24;
	localparam int SYS_RSVD23 = 23;
	localparam int SYS_DRIVE = 22;
	localparam int SYS_LOCK = 5;

	// ----------------------------------------
	// Interrupt pin report codes
	// ----------------------------------------
	localparam logic [7:0] PIN_INTA = 8'h01;
	localparam logic [7:0] PIN_INTB = 8'h02;

	// Identification load sequencer
	typedef enum logic [2:0] {
		LD_IDLE = 3'b001,
		LD_WAIT = 3'b010,
		LD_DONE = 3'b100
	} cbc_load_t;

endpackage

// ### design/cbc_irq_route.sv
// Interrupt tying and serial slot rotation for the three interrupt lines.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/1ps
module cbc_irq_route import cbc_pkg::*; (
	// Interrupt sources, bit 0 is A
	input wire logic [2:0] irq_in,
	// Controls
	input wire logic serial_mode,
	input wire logic [1:0] slot_shift,
	input wire logic tie_ab,
	input wire logic tie_all,
	// Results
	output logic [3:0] slot,
	output logic [7:0] pin_code
);
	logic [3:0] tied;
	logic [1:0] shift_eff;

	// Merge lines onto A; C survives a plain A/B tie
	always_comb begin
		tied = {1'b0, irq_in};
		if (tie_all) begin
			tied = {3'b000, |irq_in};
		end else if (tie_ab) begin
			tied = {1'b0, irq_in[2], 1'b0, irq_in[0] | irq_in[1]};
		end
	end

	// Rotation only has meaning in the serial frame
	assign shift_eff = serial_mode ? slot_shift : 2'b00;

	// Each slot picks the line that lands on it after rotation
	genvar s;
	generate
		for (s = 0; s < 4; s++) begin : g_slot
			logic [1:0] idx;
			assign idx = 2'(s) - shift_eff;
			assign slot[s] = tied[idx];
		end
	endgenerate

	// Second function reports INTA once its line is tied away
	assign pin_code = (tie_ab | tie_all) ? PIN_INTA : PIN_INTB;
endmodule

// ### design/cbc_config_regs.sv
// Configuration register group of a two-function card bridge: identification,
// legacy index base and upper system setup bits.
// Assumes one-cycle configuration strobes and a separate identification loader.
`timescale 1ns/1ps
// Operation
// - Identification registers writable only while the write lock bit is clear.
// - Identification and legacy base cleared only by global reset.
// - Attached EEPROM loads both identification values after any reset.
// - Maker identification at 40h in both functions, resets to zero.
// - Product identification at 42h in both functions.
// - I/O at base selects index register; base plus one selects data.
// - Legacy base anywhere in I/O space on word boundary; bit 0 reads 1.
// - One legacy base at 44h shared by both functions, reset 0000 0001h.
// - System setup at 80h, reset 0800 9060h; global bits via function 0; bit 28 is also written via function 1.
// - Slot shift field rotates the interrupt lines over the four serial interrupt slots.
// - Bit 29 ties B onto A, reported in pin register; C untouched.
// - Bit 28 ties A, B and C onto A, reported in pin register.
// - Bit 27 reserved, reads 1; oscillator stays enabled regardless.
// - Bit 26 routes power interrupts to IRQ2 or card status change.
// - Per-socket flag set on power write when enabled; write 1 clears.
// - Bit 24 enables interrupt on socket power control writes, resets 0.
// - Bit 22 drives reserved card pins low while card present.
// - Bit 23 is read-only zero.
// - Write lock resets to 1 and is exported for other ID registers.
module cbc_config_regs import cbc_pkg::*; (
	// Clock and resets
	input wire logic mclk,
	input wire logic rst,
	input wire logic bus_reset,
	// Configuration access
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic cfg_func,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic cfg_ack,
	output logic [31:0] cfg_rdata,
	// Identification loader
	input wire logic eeprom_present,
	input wire logic eeprom_valid,
	input wire logic [15:0] eeprom_maker,
	input wire logic [15:0] eeprom_product,
	output logic eeprom_load_req,
	// Legacy index decode
	input wire logic io_valid,
	input wire logic [31:0] io_addr,
	output logic legacy_index_sel,
	output logic legacy_data_sel,
	// Interrupt lines
	input wire logic [2:0] irq_in,
	input wire logic serial_mode,
	output logic [3:0] irq_slot,
	output logic [7:0] irq_pin_report,
	// Socket power events
	input wire logic [1:0] socket_power_write,
	output logic power_irq2,
	output logic [1:0] card_status_change,
	// Reserved card pins
	input wire logic [1:0] cardbus_present,
	output logic [1:0] rsvd_pin_o,
	output logic [1:0] rsvd_pin_oe,
	// Lock for other identification registers
	output logic ident_write_lock
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [15:0] maker_q, product_q;
	logic [31:1] legacy_q;
	logic [1:0] shift_q;
	logic tie_ab_q, tie_all_q, route_q, enable_q, lock_q;
	logic [1:0] flag_q, drive_q;
	cbc_load_t ld_q, ld_d;
	logic [3:0] slot_c;
	logic [7:0] pin_c;

	// Decode: 42h lives in the upper half of the 40h dword
	logic hit_id, hit_leg, hit_sys, wr_id, wr_leg, wr_sys, wr_glob, load_now;
	assign hit_id = cfg_addr[7:2] == OFS_MAKER[7:2];
	assign hit_leg = cfg_addr[7:2] == OFS_LEGACY[7:2];
	assign hit_sys = cfg_addr[7:2] == OFS_SYS[7:2];
	assign wr_id = cfg_wr && hit_id && !lock_q;
	assign wr_leg = cfg_wr && hit_leg;
	assign wr_sys = cfg_wr && hit_sys;
	assign wr_glob = wr_sys && !cfg_func;
	assign load_now = (ld_q == LD_WAIT) && eeprom_valid;

	// ----------------------------------------
	// Identification loader sequencer
	// ----------------------------------------
	// Any reset restarts the load so the zero defaults get replaced again
	always_comb begin
		ld_d = ld_q;
		case (ld_q)
			LD_IDLE: ld_d = eeprom_present ? LD_WAIT : LD_DONE;
			LD_WAIT: if (eeprom_valid) begin
				ld_d = LD_DONE;
			end
			LD_DONE: ld_d = LD_DONE;
			default: ld_d = LD_IDLE;
		endcase
		if (bus_reset) begin
			ld_d = LD_IDLE;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ld_q <= LD_IDLE;
			eeprom_load_req <= 1'b0;
		end else begin
			ld_q <= ld_d;
			eeprom_load_req <= ld_d == LD_WAIT;
		end
	end

	// ----------------------------------------
	// Identification registers
	// ----------------------------------------
	// Only rst clears these; bus_reset deliberately absent. Loader beats software.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			maker_q <= MAKER_RST;
			product_q <= PRODUCT_RST;
		end else if (load_now) begin
			maker_q <= eeprom_maker;
			product_q <= eeprom_product;
		end else if (wr_id) begin
			if (cfg_be[0]) maker_q[7:0] <= cfg_wdata[7:0];
			if (cfg_be[1]) maker_q[15:8] <= cfg_wdata[15:8];
			if (cfg_be[2]) product_q[7:0] <= cfg_wdata[23:16];
			if (cfg_be[3]) product_q[15:8] <= cfg_wdata[31:24];
		end
	end

	// ----------------------------------------
	// Legacy index base
	// ----------------------------------------
	// One copy for both functions; bit 0 has no storage at all
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			legacy_q <= LEGACY_RST[31:1];
		end else if (wr_leg) begin
			if (cfg_be[0]) legacy_q[7:1] <= cfg_wdata[7:1];
			if (cfg_be[1]) legacy_q[15:8] <= cfg_wdata[15:8];
			if (cfg_be[2]) legacy_q[23:16] <= cfg_wdata[23:16];
			if (cfg_be[3]) legacy_q[31:24] <= cfg_wdata[31:24];
		end
	end

	// Index at the word base, data one above it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			legacy_index_sel <= 1'b0;
			legacy_data_sel <= 1'b0;
		end else begin
			legacy_index_sel <= io_valid && io_addr == {legacy_q, 1'b0};
			legacy_data_sel <= io_valid && io_addr == {legacy_q, 1'b1};
		end
	end

	// ----------------------------------------
	// System setup: global bits
	// ----------------------------------------
	// Function 1 writes to global bits are dropped, except bit 28, which either function writes
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			shift_q <= SYS_RST[SYS_SHIFT_LO+1:SYS_SHIFT_LO];
			tie_ab_q <= SYS_RST[SYS_TIE_AB];
			tie_all_q <= SYS_RST[SYS_TIE_ALL];
			route_q <= SYS_RST[SYS_ROUTE];
			enable_q <= SYS_RST[SYS_ENABLE];
			lock_q <= SYS_RST[SYS_LOCK];
		end else begin
			if (wr_glob && cfg_be[3]) begin
				shift_q <= cfg_wdata[SYS_SHIFT_LO+1:SYS_SHIFT_LO];
				tie_ab_q <= cfg_wdata[SYS_TIE_AB];
				route_q <= cfg_wdata[SYS_ROUTE];
				enable_q <= cfg_wdata[SYS_ENABLE];
			end
			if (wr_sys && cfg_be[3]) begin
				tie_all_q <= cfg_wdata[SYS_TIE_ALL];
			end
			if (wr_glob && cfg_be[0]) begin
				lock_q <= cfg_wdata[SYS_LOCK];
			end
		end
	end

	// ----------------------------------------
	// System setup: per-socket bits
	// ----------------------------------------
	genvar f;
	generate
		for (f = 0; f < 2; f++) begin : g_sock
			logic set_c, clr_c;
			assign set_c = socket_power_write[f] && enable_q;
			assign clr_c = wr_sys && cfg_func == 1'(f) && cfg_be[3] && cfg_wdata[SYS_FLAG];
			// A power write in the clearing cycle still leaves the flag set while bit 24 is enabled
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					flag_q[f] <= SYS_RST[SYS_FLAG];
					drive_q[f] <= SYS_RST[SYS_DRIVE];
				end else begin
					flag_q[f] <= (flag_q[f] && !clr_c) || set_c;
					if (wr_sys && cfg_func == 1'(f) && cfg_be[2]) begin
						drive_q[f] <= cfg_wdata[SYS_DRIVE];
					end
				end
			end
			// Pins only ever driven low, otherwise released
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					rsvd_pin_oe[f] <= 1'b0;
					rsvd_pin_o[f] <= 1'b0;
				end else begin
					rsvd_pin_oe[f] <= drive_q[f] && cardbus_present[f];
					rsvd_pin_o[f] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Power change interrupt steering
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			power_irq2 <= 1'b0;
			card_status_change <= 2'b00;
		end else begin
			power_irq2 <= enable_q && !route_q && |socket_power_write;
			card_status_change <= (enable_q && route_q) ? socket_power_write : 2'b00;
		end
	end

	// ----------------------------------------
	// Interrupt routing
	// ----------------------------------------
	cbc_irq_route u_route (
		.irq_in(irq_in),
		.serial_mode(serial_mode),
		.slot_shift(shift_q),
		.tie_ab(tie_ab_q),
		.tie_all(tie_all_q),
		.slot(slot_c),
		.pin_code(pin_c)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_slot <= 4'h0;
			irq_pin_report <= PIN_INTB;
			ident_write_lock <= SYS_RST[SYS_LOCK];
		end else begin
			irq_slot <= slot_c;
			irq_pin_report <= pin_c;
			ident_write_lock <= lock_q;
		end
	end

	// ----------------------------------------
	// Read data and completion
	// ----------------------------------------
	// Bits 21:16 belong to other logic and read zero here
	logic [31:0] sys_rd;
	always_comb begin
		sys_rd = SYS_RST & 32'h0000_FFFF;
		sys_rd[SYS_LOCK] = lock_q;
		sys_rd[SYS_SHIFT_LO+1:SYS_SHIFT_LO] = shift_q;
		sys_rd[SYS_TIE_AB] = tie_ab_q;
		sys_rd[SYS_TIE_ALL] = tie_all_q;
		sys_rd[SYS_OSC_RSVD] = SYS_RST[SYS_OSC_RSVD];
		sys_rd[SYS_ROUTE] = route_q;
		sys_rd[SYS_FLAG] = flag_q[cfg_func];
		sys_rd[SYS_ENABLE] = enable_q;
		sys_rd[SYS_RSVD23] = SYS_RST[SYS_RSVD23];
		sys_rd[SYS_DRIVE] = drive_q[cfg_func];
	end

	// Every strobe is answered next cycle; unmapped reads return zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_ack <= 1'b0;
			cfg_rdata <= 32'h0000_0000;
		end else begin
			cfg_ack <= cfg_rd || cfg_wr;
			if (cfg_rd) begin
				if (hit_id) begin
					cfg_rdata <= {product_q, maker_q};
				end else if (hit_leg) begin
					cfg_rdata <= {legacy_q, 1'b1};
				end else if (hit_sys) begin
					cfg_rdata <= sys_rd;
				end else begin
					cfg_rdata <= 32'h0000_0000;
				end
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_lock_hold;
		@(posedge mclk) disable iff (rst)
		cfg_wr && hit_id && lock_q && !load_now |=> $stable(maker_q) && $stable(product_q);
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("locked id changed");

	property p_bus_reset_keep;
		@(posedge mclk) disable iff (rst)
		bus_reset && !cfg_wr && !load_now |=> $stable(legacy_q) && $stable(maker_q);
	endproperty
	a_bus_reset_keep: assert property (p_bus_reset_keep) else $error("bus reset hit regs");

	property p_load;
		@(posedge mclk) disable iff (rst)
		eeprom_load_req && eeprom_valid |=> product_q == $past(eeprom_product) ##1 !eeprom_load_req;
	endproperty
	a_load: assert property (p_load) else $error("id load wrong");

	property p_index;
		@(posedge mclk) disable iff (rst)
		io_valid && io_addr == {legacy_q, 1'b1} |=> legacy_data_sel && !legacy_index_sel;
	endproperty
	a_index: assert property (p_index) else $error("data select missed");

	property p_bit0;
		@(posedge mclk) disable iff (rst)
		cfg_rd && hit_leg |=> cfg_ack && cfg_rdata[0];
	endproperty
	a_bit0: assert property (p_bit0) else $error("legacy bit 0 not 1");

	property p_func1_global;
		@(posedge mclk) disable iff (rst)
		wr_sys && cfg_func |=> $stable(enable_q) && $stable(route_q) && $stable(lock_q);
	endproperty
	a_func1_global: assert property (p_func1_global) else $error("func 1 wrote global");

	property p_flag_set;
		@(posedge mclk) disable iff (rst)
		socket_power_write[0] && enable_q |=> flag_q[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("power flag not set");

	property p_drive;
		@(posedge mclk) disable iff (rst)
		drive_q[0] && cardbus_present[0] |=> rsvd_pin_oe[0] && !rsvd_pin_o[0];
	endproperty
	a_drive: assert property (p_drive) else $error("reserved pin not driven");

	property p_tie_all;
		@(posedge mclk) disable iff (rst)
		tie_all_q && (!serial_mode || shift_q == 2'b00) && irq_in[2] |=> irq_slot[0] && !irq_slot[2];
	endproperty
	a_tie_all: assert property (p_tie_all) else $error("tie all failed");

	c_locked_write: cover property (@(posedge mclk) disable iff (rst) cfg_wr && hit_id && lock_q);
	c_load: cover property (@(posedge mclk) disable iff (rst) load_now);
	c_csc: cover property (@(posedge mclk) disable iff (rst) |card_status_change);
endmodule

// ### dv/cbc_host_model.sv
// Host model that issues configuration reads and writes, one at a time.
// Assumes the bridge acknowledges each strobe in the cycle after it is taken.
`timescale 1ns/1ps
module cbc_host_model (
	// Clock
	input wire logic mclk,
	// Configuration access
	output logic cfg_rd,
	output logic cfg_wr,
	output logic cfg_func,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata,
	input wire logic cfg_ack,
	input wire logic [31:0] cfg_rdata
);
	// Idle bus at time zero
	initial begin
		cfg_rd = 1'b0;
		cfg_wr = 1'b0;
		cfg_func = 1'b0;
		cfg_addr = 8'hFF;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end

	// Strobe one cycle, hold qualifiers until ack is sampled, then scramble address, byte enables and data
	// Callers send global setup bits through function 0, and through function 1 to check they are dropped
	task automatic access(input logic wr, input logic fn, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd, output logic ok);
		int n;
		ok = 1'b0;
		rd = 32'h0;
		@(posedge mclk);
		cfg_wr <= wr;
		cfg_rd <= !wr;
		cfg_func <= fn;
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= wd;
		// Taken at this edge; the strobe itself is a one-cycle pulse
		@(posedge mclk);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		// Look at the answer once it has settled, release at the following edge
		for (n = 0; n < 4 && !ok; n++) begin
			#1;
			ok = (cfg_ack === 1'b1);
			rd = cfg_rdata;
			@(posedge mclk);
		end
		// Released lines show no stale value
		cfg_addr <= ~cfg_addr;
		cfg_wdata <= ~cfg_wdata;
		cfg_be <= ~cfg_be;
	endtask
endmodule

// ### dv/cbc_config_regs_tb_top.sv
// Self-checking bench for the bridge configuration register group.
// Assumes the host model drives the configuration port; the bench drives the rest.
`timescale 1ns/1ps
module cbc_config_regs_tb_top import cbc_pkg::*;;
	logic mclk, rst, bus_reset, cfg_rd, cfg_wr, cfg_func, cfg_ack;
	logic [7:0] cfg_addr, irq_pin_report;
	logic [3:0] cfg_be, irq_slot;
	logic [31:0] cfg_wdata, cfg_rdata, io_addr;
	logic eeprom_present, eeprom_valid, eeprom_load_req, io_valid;
	logic [15:0] eeprom_maker, eeprom_product;
	logic legacy_index_sel, legacy_data_sel, serial_mode, power_irq2, ident_write_lock;
	logic [2:0] irq_in;
	logic [1:0] socket_power_write, card_status_change, cardbus_present, rsvd_pin_o, rsvd_pin_oe;
	int errors = 0;
	int check_count = 0;

	cbc_config_regs dut_u (.mclk(mclk), .rst(rst), .bus_reset(bus_reset), .cfg_rd(cfg_rd),
		.cfg_wr(cfg_wr), .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
		.eeprom_present(eeprom_present), .eeprom_valid(eeprom_valid),
		.eeprom_maker(eeprom_maker), .eeprom_product(eeprom_product),
		.eeprom_load_req(eeprom_load_req), .io_valid(io_valid), .io_addr(io_addr),
		.legacy_index_sel(legacy_index_sel), .legacy_data_sel(legacy_data_sel),
		.irq_in(irq_in), .serial_mode(serial_mode), .irq_slot(irq_slot),
		.irq_pin_report(irq_pin_report), .socket_power_write(socket_power_write),
		.power_irq2(power_irq2), .card_status_change(card_status_change),
		.cardbus_present(cardbus_present), .rsvd_pin_o(rsvd_pin_o),
		.rsvd_pin_oe(rsvd_pin_oe), .ident_write_lock(ident_write_lock));
	cbc_host_model host_u (.mclk(mclk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_func(cfg_func),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
		.cfg_rdata(cfg_rdata));

	// --------------------------------
	// Helpers
	// --------------------------------
	// 10 MHz clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic fn, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		logic [31:0] r;
		logic ok;
		host_u.access(1'b1, fn, a, be, d, r, ok);
		chk({31'h0, ok}, 32'h1);
	endtask

	task automatic rd(input logic fn, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic ok;
		host_u.access(1'b0, fn, a, 4'hF, 32'h0, r, ok);
		chk({31'h0, ok}, 32'h1);
		chk(r, exp);
	endtask

	// Pulse a socket power write and sample the event outputs a cycle later
	task automatic power_pulse(input logic [31:0] exp);
		@(posedge mclk);
		socket_power_write <= 2'b01;
		@(posedge mclk);
		socket_power_write <= 2'b00;
		#1;
		chk({29'h0, card_status_change[1], power_irq2, card_status_change[0]}, exp);
	endtask

	task automatic settle();
		repeat (3) @(posedge mclk);
		#1;
	endtask

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic t_reset();
		rd(1'b0, OFS_MAKER, 32'h0);
		rd(1'b1, OFS_MAKER, 32'h0);
		rd(1'b0, OFS_LEGACY, LEGACY_RST);
		rd(1'b0, OFS_SYS, SYS_RST);
		rd(1'b0, 8'h84, 32'h0);
		chk({31'h0, ident_write_lock}, 32'h1);
		wr(1'b0, OFS_MAKER, 4'hF, 32'hBEEF_CAFE);
		rd(1'b0, OFS_MAKER, 32'h0);
	endtask

	// Unlock, load identities and legacy base, decode, then survive a bus reset
	task automatic t_ident();
		wr(1'b0, OFS_SYS, 4'h1, 32'h0);
		rd(1'b0, OFS_SYS, 32'h0800_9040);
		chk({31'h0, ident_write_lock}, 32'h0);
		wr(1'b0, OFS_MAKER, 4'h3, 32'h0000_1234);
		wr(1'b1, OFS_PRODUCT, 4'hC, 32'h5678_0000);
		rd(1'b1, OFS_MAKER, 32'h5678_1234);
		wr(1'b1, OFS_LEGACY, 4'hF, 32'h1234_5678);
		rd(1'b0, OFS_LEGACY, 32'h1234_5679);
		@(posedge mclk);
		io_valid <= 1'b1;
		io_addr <= 32'h1234_5678;
		@(posedge mclk);
		io_addr <= 32'h1234_5679;
		#1;
		chk({30'h0, legacy_index_sel, legacy_data_sel}, 32'h2);
		@(posedge mclk);
		io_valid <= 1'b0;
		#1;
		chk({30'h0, legacy_index_sel, legacy_data_sel}, 32'h1);
		@(posedge mclk);
		bus_reset <= 1'b1;
		@(posedge mclk);
		bus_reset <= 1'b0;
		rd(1'b0, OFS_MAKER, 32'h5678_1234);
		rd(1'b1, OFS_LEGACY, 32'h1234_5679);
	endtask

	task automatic t_power();
		power_pulse(32'h0);
		wr(1'b1, OFS_SYS, 4'hF, 32'h0100_9040);
		rd(1'b0, OFS_SYS, 32'h0800_9040);
		wr(1'b0, OFS_SYS, 4'hF, 32'h0100_9040);
		power_pulse(32'h2);
		rd(1'b0, OFS_SYS, 32'h0B00_9040);
		wr(1'b0, OFS_SYS, 4'hF, 32'h0300_9040);
		rd(1'b0, OFS_SYS, 32'h0900_9040);
		wr(1'b0, OFS_SYS, 4'hF, 32'h0500_9040);
		power_pulse(32'h1);
	endtask

	task automatic t_irq();
		int s;
		serial_mode <= 1'b1;
		irq_in <= 3'b001;
		for (s = 0; s < 4; s++) begin
			wr(1'b0, OFS_SYS, 4'h8, {s[1:0], 30'h0});
			settle();
			chk({28'h0, irq_slot}, 32'h1 << s);
		end
		wr(1'b0, OFS_SYS, 4'h8, 32'h2000_0000);
		irq_in <= 3'b010;
		settle();
		chk({20'h0, irq_slot, irq_pin_report}, 32'h101);
		irq_in <= 3'b100;
		settle();
		chk({28'h0, irq_slot}, 32'h4);
		wr(1'b0, OFS_SYS, 4'h8, 32'h1000_0000);
		settle();
		chk({20'h0, irq_slot, irq_pin_report}, 32'h101);
	endtask

	task automatic t_pins();
		cardbus_present <= 2'b01;
		wr(1'b0, OFS_SYS, 4'h4, 32'h00C0_0000);
		rd(1'b0, OFS_SYS, 32'h1A40_9040);
		settle();
		chk({28'h0, rsvd_pin_o, rsvd_pin_oe}, 32'h1);
	endtask

	task automatic t_eeprom();
		int n;
		eeprom_present <= 1'b1;
		@(posedge mclk);
		bus_reset <= 1'b1;
		@(posedge mclk);
		bus_reset <= 1'b0;
		for (n = 0; n < 8 && eeprom_load_req !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		chk({31'h0, eeprom_load_req}, 32'h1);
		@(posedge mclk);
		eeprom_valid <= 1'b1;
		eeprom_maker <= 16'hAAAA;
		eeprom_product <= 16'h5555;
		@(posedge mclk);
		eeprom_valid <= 1'b0;
		rd(1'b0, OFS_MAKER, 32'h5555_AAAA);
		chk({31'h0, eeprom_load_req}, 32'h0);
	endtask

	// --------------------------------
	// Run control
	// --------------------------------
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence after a ten cycle global reset
	initial begin
		{rst, bus_reset, eeprom_present, eeprom_valid, io_valid, serial_mode} = 6'b100000;
		{eeprom_maker, eeprom_product, io_addr} = 64'h0;
		{irq_in, socket_power_write, cardbus_present} = 7'h0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_ident();
		t_power();
		t_irq();
		t_pins();
		t_eeprom();
		summarize();
	end

	// Watchdog well beyond the roughly 150 cycles the scenarios need
	initial begin
		#400000;
		errors++;
		summarize();
	end
endmodule
